// >>> hw/fea_addr_unit.sv
// Address-forming unit of a serial flash: turns command address bytes
// into a 32-bit byte address. Assumes decoded command and byte strobes.
//
// Summary of operation
// R1: With extended mode off, legacy commands take a 3-byte address.
// R2: A command-loaded bank value supplies bits above the 24 sent bits.
// R3: Extended mode bit set makes every legacy command take four bytes.
// R4: Newer command codes always take four address bytes.
// R5: Reset clears the bank value and selects 3-byte legacy addressing.
// R6: Lower-density build forces address bits 31 to 24 to zero outside separate address spaces.
// R7: Separate address spaces use the full 32-bit formation unmasked.
// R8: Legacy address is bank value on 31:24 joined to the 24 bits.
`timescale 1ns/1ps
module fea_addr_unit
	import fea_pkg::*;
#(
	parameter int DENSITY_BITS = FULL_DENSITY
) (
	input  wire logic              sys_clk,
	input  wire logic              rst,
	input  wire fea_cmd_s          cmdIn,
	input  wire logic              bankWrite,
	input  wire logic [7:0]        bankData,
	input  wire logic              addrByteValid,
	input  wire logic [7:0]        addrByte,
	output fea_addr_s              addrOut,
	output logic                   addrValid,
	output logic      [7:0]        bankValue,
	output logic                   extMode,
	output logic      [2:0]        needBytes,
	output logic                   collecting
);

	generate
		if (DENSITY_BITS != FULL_DENSITY &&
		    DENSITY_BITS != LOW_DENSITY) begin : g_bad
			$error("fea_addr_unit: DENSITY_BITS must be 24 or 32");
		end
	endgenerate

	fea_state_e       state;
	fea_state_e       next_state;
	logic             sepLatched;
	logic [31:0]      shiftVal;
	logic [2:0]       byteCount;

	// Width chosen at command start, held until the next start
	wire logic        wantFour = cmdIn.fourByteCmd | extMode;
	wire logic [2:0]  next_need = wantFour ? EXT_BYTES      // [R3] [R4]
	                                       : LEGACY_BYTES;  // [R1]
	wire logic        takeByte = (state == COLLECT) & addrByteValid
	                             & ~cmdIn.start;
	wire logic        lastByte = takeByte & (byteCount == needBytes - 3'h1);
	wire logic [31:0] rawFour  = {shiftVal[23:0], addrByte};
	wire logic [31:0] rawThree = {bankValue, shiftVal[15:0], addrByte}; // [R2] [R8]
	wire logic [31:0] rawAddr  = (needBytes == EXT_BYTES) ? rawFour
	                                                      : rawThree;
	wire logic        lowDens  = (DENSITY_BITS == LOW_DENSITY);
	wire logic        maskHigh = lowDens & ~sepLatched;
	wire logic [31:0] next_addr = maskHigh ? {8'h00, rawAddr[23:0]} // [R6]
	                                       : rawAddr;               // [R7]

	assign extMode    = bankValue[EXT_BIT];
	assign collecting = (state == COLLECT);

	fea_byte_collect #(
		.MAXB     (MAX_BYTES)
	) u_collect (
		.sys_clk  (sys_clk),
		.rst      (rst),
		.clear    (cmdIn.start),
		.take     (takeByte),
		.byteIn   (addrByte),
		.shiftOut (shiftVal),
		.countOut (byteCount)
	);

	always_comb begin
		next_state = state;
		case (state)
			IDLE: begin
				if (cmdIn.start)
					next_state = COLLECT;
			end
			COLLECT: begin
				// A new start restarts collection
				if (cmdIn.start)
					next_state = COLLECT;
				else if (lastByte)
					next_state = IDLE;
			end
			default: next_state = IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			state <= IDLE;
		else
			state <= next_state;
	end

	// Bank value and width selection
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			bankValue <= BANK_RESET;   // [R5]
			needBytes <= LEGACY_BYTES; // [R5]
			sepLatched <= 1'b0;
		end else begin
			if (bankWrite)
				bankValue <= bankData; // [R2]
			if (cmdIn.start) begin
				needBytes  <= next_need;
				sepLatched <= cmdIn.separateSpace;
			end
		end
	end

	// Formed address, valid for one cycle
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			addrOut   <= '0;
			addrValid <= 1'b0;
		end else begin
			addrValid <= lastByte;
			if (lastByte) begin
				addrOut.addr          <= next_addr;
				addrOut.separateSpace <= sepLatched;
			end
		end
	end

	// Checks

	sequence s_legacyStart;
		cmdIn.start && !cmdIn.fourByteCmd && !extMode;
	endsequence

	sequence s_fourLast;
		lastByte && needBytes == EXT_BYTES;
	endsequence

	sequence s_threeLast;
		lastByte && needBytes == LEGACY_BYTES && !maskHigh;
	endsequence

	property p_resetDefaults;
		@(posedge sys_clk)
		$fell(rst) |-> bankValue == 8'h00 && needBytes == 3'h3 && !extMode;
	endproperty
	a_resetDefaults: assert property (p_resetDefaults) // [R5]
		else $error("bank or width not at reset default");

	property p_legacyNeed;
		@(posedge sys_clk) disable iff (rst)
		s_legacyStart |=> needBytes == 3'h3 && collecting;
	endproperty
	a_legacyNeed: assert property (p_legacyNeed) // [R1]
		else $error("legacy command not set to three bytes");

	property p_extNeed;
		@(posedge sys_clk) disable iff (rst)
		cmdIn.start && extMode |=> needBytes == 3'h4;
	endproperty
	a_extNeed: assert property (p_extNeed) // [R3]
		else $error("extended mode did not select four bytes");

	property p_newNeed;
		@(posedge sys_clk) disable iff (rst)
		cmdIn.start && cmdIn.fourByteCmd |=> needBytes == 3'h4;
	endproperty
	a_newNeed: assert property (p_newNeed) // [R4]
		else $error("new command did not select four bytes");

	property p_bankLoad;
		@(posedge sys_clk) disable iff (rst)
		bankWrite |=> bankValue == $past(bankData);
	endproperty
	a_bankLoad: assert property (p_bankLoad) // [R2]
		else $error("bank value not loaded");

	property p_legacyForm;
		@(posedge sys_clk) disable iff (rst)
		s_threeLast |=> addrValid
			&& addrOut.addr[31:24] == $past(bankValue)
			&& addrOut.addr[7:0] == $past(addrByte);
	endproperty
	a_legacyForm: assert property (p_legacyForm) // [R8]
		else $error("legacy address not bank joined to bytes");

	property p_fourForm;
		@(posedge sys_clk) disable iff (rst)
		s_fourLast ##0 (!maskHigh) |=> addrValid
			&& addrOut.addr == {$past(shiftVal[23:0]), $past(addrByte)};
	endproperty
	a_fourForm: assert property (p_fourForm) // [R7]
		else $error("four-byte address not taken in full");

	property p_lowDensity;
		@(posedge sys_clk) disable iff (rst)
		addrValid && !addrOut.separateSpace && lowDens
			|-> addrOut.addr[31:24] == 8'h00;
	endproperty
	a_lowDensity: assert property (p_lowDensity) // [R6]
		else $error("high address bits not ignored");

	property p_validPulse;
		@(posedge sys_clk) disable iff (rst)
		addrValid |-> $past(collecting) && !collecting [*1] ##1 !addrValid;
	endproperty
	a_validPulse: assert property (p_validPulse)
		else $error("address valid not a single pulse after collection");

endmodule

// >>> hw/fea_byte_collect.sv
// Shift register that gathers address bytes, most significant first.
// Assumes the caller clears it at each command start.
`timescale 1ns/1ps
module fea_byte_collect
	import fea_pkg::*;
#(
	parameter int MAXB = MAX_BYTES
) (
	input  wire logic              sys_clk,
	input  wire logic              rst,
	input  wire logic              clear,
	input  wire logic              take,
	input  wire logic [7:0]        byteIn,
	output logic      [31:0]       shiftOut,
	output logic      [2:0]        countOut
);

	generate
		if (MAXB < 1 || MAXB > 4) begin : g_bad
			$error("fea_byte_collect: MAXB must be 1 to 4");
		end
	endgenerate

	wire logic [31:0] next_shift = {shiftOut[23:0], byteIn};
	wire logic [2:0]  next_count = countOut + 3'h1;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			shiftOut <= 32'h0000_0000;
			countOut <= 3'h0;
		end else if (clear) begin
			shiftOut <= 32'h0000_0000;
			countOut <= 3'h0;
		end else if (take) begin
			shiftOut <= next_shift;
			countOut <= next_count;
		end
	end

endmodule

// >>> shared/fea_pkg.sv
// Constants, carrier structs and states of the flash address-forming unit.
// Assumes a command decoder ahead of it that marks command start and bytes.
package fea_pkg;

	localparam int          ADDR_W       = 32;
	localparam int          BYTE_W       = 8;
	localparam int          LEGACY_W     = 24;
	localparam int          FULL_DENSITY = 32;
	localparam int          LOW_DENSITY  = 24;
	localparam int          MAX_BYTES    = 4;
	localparam logic [2:0]  LEGACY_BYTES = 3'h3;
	localparam logic [2:0]  EXT_BYTES    = 3'h4;
	localparam logic [7:0]  BANK_RESET   = 8'h00;
	localparam int          EXT_BIT      = 7;

	// One command as seen by the address unit
	typedef struct packed {
		logic start;
		logic fourByteCmd;
		logic separateSpace;
	} fea_cmd_s;

	// One formed address
	typedef struct packed {
		logic [31:0] addr;
		logic        separateSpace;
	} fea_addr_s;

	typedef enum logic {
		IDLE,
		COLLECT
	} fea_state_e;

endpackage

// >>> test/fea_host_model.sv
// Host controller model: issues bank loads and address commands.
// Assumes the unit samples its inputs on the rising clock edge.
`timescale 1ns/1ps
module fea_host_model
	import fea_pkg::*;
(
	input  wire logic       sys_clk,
	output fea_cmd_s        cmdIn,
	output logic            bankWrite,
	output logic      [7:0] bankData,
	output logic            addrByteValid,
	output logic      [7:0] addrByte
);
	initial begin
		cmdIn = '0;
		bankWrite = 1'b0;
		bankData = 8'h00;
		addrByteValid = 1'b0;
		addrByte = 8'h00;
	end
	task automatic load_bank(input logic [7:0] b);
		@(posedge sys_clk);
		bankWrite <= 1'b1;
		bankData <= b;
		@(posedge sys_clk);
		bankWrite <= 1'b0;
		bankData <= ~b;
	endtask
	// Byte count chosen by caller per mode and code
	task automatic send(input logic f, s, input int n, input logic [31:0] a);
		@(posedge sys_clk);
		cmdIn <= '{1'b1, f, s};
		for (int i = 0; i < n; i++) begin
			@(posedge sys_clk);
			cmdIn <= '{1'b0, f, s};
			addrByteValid <= 1'b1;
			addrByte <= a[8*(n-1-i) +: 8];
		end
		@(posedge sys_clk);
		addrByteValid <= 1'b0;
		addrByte <= ~addrByte;
	endtask
endmodule

// >>> test/test_fea_addr_unit.sv
// Testbench: full and low-density units fed by one host model.
// Assumes a 100 MHz clock and an active-high asynchronous reset.
`timescale 1ns/1ps
module test_fea_addr_unit
	import fea_pkg::*;
;
	logic       sys_clk;
	logic       rst;
	fea_cmd_s   cmdIn;
	logic       bankWrite;
	logic [7:0] bankData;
	logic       addrByteValid;
	logic [7:0] addrByte;
	fea_addr_s  addrOut;
	fea_addr_s  lowAddrOut;
	logic       addrValid;
	logic [7:0] bankValue;
	logic       extMode;
	logic [2:0] needBytes;
	logic       collecting;
	int         err_total = 0;
	int         n_tests = 0;

	fea_host_model i_fea_host_model (.sys_clk(sys_clk), .cmdIn(cmdIn),
		.bankWrite(bankWrite), .bankData(bankData),
		.addrByteValid(addrByteValid), .addrByte(addrByte));
	fea_addr_unit i_fea_addr_unit (.sys_clk(sys_clk), .rst(rst),
		.cmdIn(cmdIn), .bankWrite(bankWrite), .bankData(bankData),
		.addrByteValid(addrByteValid), .addrByte(addrByte),
		.addrOut(addrOut), .addrValid(addrValid), .bankValue(bankValue),
		.extMode(extMode), .needBytes(needBytes),
		.collecting(collecting));
	fea_addr_unit #(.DENSITY_BITS(LOW_DENSITY)) i_fea_addr_unit_low (
		.sys_clk(sys_clk), .rst(rst), .cmdIn(cmdIn),
		.bankWrite(bankWrite), .bankData(bankData),
		.addrByteValid(addrByteValid), .addrByte(addrByte),
		.addrOut(lowAddrOut), .addrValid(), .bankValue(), .extMode(),
		.needBytes(), .collecting());

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	task automatic conclude();
		$display("Checks %0d, mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input logic [32:0] got, exp, input string msg);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	task automatic run(input logic f, s, input int n,
		input logic [31:0] a, ef, el);
		int k;
		k = 0;
		i_fea_host_model.send(f, s, n, a);
		#1;
		while (addrValid !== 1'b1 && k < 4) begin
			@(posedge sys_clk);
			#1;
			k++;
		end
		if (k == 4) begin
			chk(1'b0, 1'b1, "no result");
			conclude();
		end
		chk(addrOut, {ef, s}, "full addr");
		chk(lowAddrOut, {el, s}, "low addr");
		chk(needBytes, n[2:0], "byte count");
		chk(collecting, 1'b0, "collect done");
		@(posedge sys_clk);
		#1;
		chk(addrValid, 1'b0, "valid pulse");
	endtask

	task automatic sc_defaults();
		chk({bankValue, extMode}, 9'h000, "bank");
		chk(needBytes, LEGACY_BYTES, "width");
		chk(addrOut, 33'h0_0000_0000, "addr reset");
		chk({addrValid, collecting}, 2'h0, "flags reset");
	endtask

	// Stray partial command, then a full one that must restart collection
	task automatic sc_restart();
		i_fea_host_model.send(0, 0, 1, 32'h000000aa);
		run(0, 0, 3, 32'h00445566, 32'h00445566, 32'h00445566);
	endtask

	task automatic sc_bank(input logic [7:0] b);
		i_fea_host_model.load_bank(b);
		#1;
		chk({bankValue, extMode}, {b, b[7]}, "bank load");
	endtask

	task automatic sc_reset();
		@(posedge sys_clk);
		rst <= 1'b1;
		@(posedge sys_clk);
		rst <= 1'b0;
		#1;
		sc_defaults();
		run(0, 0, 3, 32'h00010203, 32'h00010203, 32'h00010203);
	endtask

	initial begin
		rst = 1'b1;
		repeat (8) @(posedge sys_clk);
		rst <= 1'b0;
		#1;
		sc_defaults();
		run(0, 0, 3, 32'h00123456, 32'h00123456, 32'h00123456);
		sc_restart();
		sc_bank(8'h25);
		run(0, 0, 3, 32'h00abcdef, 32'h25abcdef, 32'h00abcdef);
		run(1, 0, 4, 32'h87654321, 32'h87654321, 32'h00654321);
		sc_bank(8'h81);
		run(0, 0, 4, 32'hfedcba98, 32'hfedcba98, 32'h00dcba98);
		run(1, 0, 4, 32'h11223344, 32'h11223344, 32'h00223344);
		run(0, 1, 4, 32'h5a000010, 32'h5a000010, 32'h5a000010);
		sc_bank(8'h03);
		run(0, 1, 3, 32'h00000010, 32'h03000010, 32'h03000010);
		sc_reset();
		conclude();
	end
endmodule
